// ===== rtl/lsl_cell.sv
// Notes on behaviour
// - Each generator is any 4-input function
// - Slice holds two generators, two storage elements
// - Generator output feeds slice and storage
// - Five-input combiner merges both generators
// - Wide combiner acts six/seven/eight by position
// - Storage is flip-flop or latch
// - Storage data from generator or bypass
// - Clock enable high; unused means enabled
// - Set/reset forces the chosen force value
// - Bypass high input forces opposite value
// - Init value from separate init attributes
// - Set/reset synchronous or asynchronous per slice
// - Seven set/reset options per slice
// - Reset wins over set
// - Shared controls, each with own polarity
// - Cell is four slices, two columns
// - Generator usable as 16x1 memory
// - Cell memory shapes single and dual port
// - Combinational read, registered via storage
// - Write enable active high on set/reset
// - Fixed generator counts per memory shape
// - Dual port: write/read plus read-only port
// - Shared address single; split in dual
`timescale 1ns/1ps
`include "lsl_params.svh"
module lsl_cell
   import lsl_pkg::*;
#(
   parameter int NSLICE = `LSL_SLICES
)
(
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    clk_en,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic                         hreadyout,
   output logic                         hresp,
   output logic      [31:0]             hrdata,
   input  wire logic [NSLICE*8-1:0]     gen_in,
   input  wire logic [NSLICE-1:0]       bypass_in_lo,
   input  wire logic [NSLICE-1:0]       bypass_in_hi,
   input  wire logic [NSLICE-1:0]       storage_clk,
   input  wire logic [NSLICE-1:0]       storage_ce,
   input  wire logic [NSLICE-1:0]       set_reset_in,
   input  wire logic                    ext_f7_in,
   input  wire logic [6:0]              mem_addr,
   input  wire logic [6:0]              mem_addr_b,
   input  wire logic [7:0]              mem_wdata,
   output logic      [NSLICE*2-1:0]     gen_out,
   output logic      [NSLICE*2-1:0]     store_out,
   output logic      [NSLICE-1:0]       f5_out,
   output logic      [NSLICE-1:0]       fx_out,
   output logic      [7:0]              mem_rdata_a,
   output logic      [3:0]              mem_rdata_b
);
   localparam int NGEN = NSLICE*2;
   localparam int LW   = `LSL_LUT_W;

   if (NSLICE != `LSL_SLICES)
   begin : g_bad
      $error("lsl_cell: cell must hold exactly four slices");
   end

   // Configuration and bus state
   lsl_slice_cfg_t        slice_cfg_reg [NSLICE];
   lsl_mem_mode_t         mem_mode_reg;
   lsl_ahb_req_t          req_reg;
   lsl_bus_state_t        bus_state_reg;
   logic                  wr_pend_reg;
   logic                  init_req_reg;
   logic                  hreadyout_reg;
   logic [31:0]           hrdata_reg;
   logic [NGEN*LW-1:0]    table_q;
   logic [NGEN*LW-1:0]    bit_we;
   logic [NGEN*LW-1:0]    bit_wd;
   logic [NSLICE-1:0]     clk_prev_reg;
   logic [NGEN-1:0]       store_reg;
   logic [NGEN-1:0]       store_next;
   logic [NGEN-1:0]       gen_out_reg;
   logic [NGEN-1:0]       gen_comb;
   logic [NSLICE-1:0]     f5_comb;
   logic [NSLICE-1:0]     fx_comb;
   logic [NSLICE-1:0]     f5_reg;
   logic [NSLICE-1:0]     fx_reg;
   logic [7:0]            rd_a_comb;
   logic [3:0]            rd_b_comb;
   logic [7:0]            rd_a_reg;
   logic [3:0]            rd_b_reg;

   // Bus decode
   wire       ahb_go   = hsel && htrans[1] && hready;
   wire [5:0] wr_idx   = req_reg.addr[7:2];
   wire       wr_fire  = wr_pend_reg;
   wire       wr_lut   = wr_fire && (wr_idx <= `LSL_IDX_LUT_LAST);
   wire       wr_mode  = wr_fire && (wr_idx == `LSL_IDX_CELL_CFG);
   wire       wr_ctrl  = wr_fire && (wr_idx == `LSL_IDX_CTRL);
   wire       ctrl_init = wr_ctrl && hwdata[`LSL_CTRL_INIT_BIT];

   // Memory mode decode
   wire       mem_on   = (mem_mode_reg != LSL_MEM_LUT);
   wire       dual     = (mem_mode_reg >= LSL_MEM_DP16X4);
   wire [1:0] lg       = dual ? 2'(mem_mode_reg - LSL_MEM_DP16X4)
                              : 2'(mem_mode_reg - LSL_MEM_SP16X8);
   wire [2:0] gmask    = 3'((4'h1 << lg) - 4'h1);
   wire [3:0] width    = dual ? 4'(4'h4 >> lg) : 4'(4'h8 >> lg);
   // Edges judged on the raw pin, so a polarity write makes no edge
   wire       wr_clk0  = storage_clk[0] ^ slice_cfg_reg[0].clk_inv;
   wire       wr_edge  = wr_clk0 && !(clk_prev_reg[0] ^ slice_cfg_reg[0].clk_inv);
   wire       mem_we   = set_reset_in[0] ^ slice_cfg_reg[0].sr_inv;
   wire       mem_wr   = mem_on && mem_we && wr_edge;
   wire [2:0] wr_grp   = mem_addr[6:4] & gmask;
   wire [2:0] rda_grp  = mem_addr[6:4] & gmask;
   wire [2:0] rdb_grp  = mem_addr_b[6:4] & gmask;

   // Register read mux
   logic [31:0] rd_val;
   wire  [5:0]  rd_idx = req_reg.addr[7:2];
   wire  [2:0]  rd_gen = rd_idx[2:0];
   wire  [1:0]  rd_sl  = 2'(rd_idx - `LSL_IDX_SLICE_0);
   assign rd_val =
      (rd_idx <= `LSL_IDX_LUT_LAST) ? {16'h0000, table_q[rd_gen*LW +: LW]} :
      (rd_idx == `LSL_IDX_CELL_CFG) ? {29'h0000_0000, mem_mode_reg} :
      (rd_idx >= `LSL_IDX_SLICE_0 && rd_idx <= `LSL_IDX_SLICE_3)
         ? {17'h0_0000, slice_cfg_reg[rd_sl]} :
      (rd_idx == `LSL_IDX_STATUS)
         ? {16'h0000, store_reg, gen_out_reg} :
      32'h0000_0000;

   // Generator table writes from bus load or memory mode
   for (genvar g = 0; g < NGEN; g++)
   begin : g_gen
      wire [2:0] blk  = dual ? {1'b0, 2'(g % 4)} : 3'(g);
      wire [2:0] bidx = 3'(blk >> lg);
      wire       hit  = mem_wr && ((blk & gmask) == wr_grp);
      wire [3:0] rsel = gen_in[g*4 +: 4];
      assign gen_comb[g] = table_q[g*LW + rsel];
      for (genvar j = 0; j < LW; j++)
      begin : g_ent
         wire cfg_w = wr_lut && (wr_idx[2:0] == 3'(g));
         wire mem_w = hit && (mem_addr[3:0] == 4'(j));
         assign bit_we[g*LW + j] = cfg_w || mem_w;
         assign bit_wd[g*LW + j] = cfg_w ? hwdata[j] : mem_wdata[bidx];
      end
   end

   // Memory read ports, port B only in dual shapes
   for (genvar b = 0; b < 8; b++)
   begin : g_rda
      wire [3:0] ga = 4'((4'(b) << lg) | {1'b0, rda_grp});
      wire [15:0] wa = table_q[ga[2:0]*LW +: LW];
      assign rd_a_comb[b] = mem_on && (4'(b) < width) ? wa[mem_addr[3:0]]
                                                      : 1'b0;
   end
   for (genvar b = 0; b < 4; b++)
   begin : g_rdb
      wire [3:0] gb = 4'(4'h4 + ((4'(b) << lg) | {1'b0, rdb_grp}));
      wire [15:0] wb = table_q[gb[2:0]*LW +: LW];
      assign rd_b_comb[b] = dual && (4'(b) < width) ? wb[mem_addr_b[3:0]]
                                                    : 1'b0;
   end

   // Slices
   for (genvar s = 0; s < NSLICE; s++)
   begin : g_slice
      lsl_slice_cfg_t cfg;
      assign cfg = slice_cfg_reg[s];
      wire clk_eff = storage_clk[s] ^ cfg.clk_inv;
      wire st_edge = clk_eff && !(clk_prev_reg[s] ^ cfg.clk_inv);
      wire ce_ok   = !cfg.ce_used || (storage_ce[s] ^ cfg.ce_inv);
      // Set/reset decode
      wire sr_a    = (set_reset_in[s] ^ cfg.sr_inv) && !(mem_on && s == 0);
      wire by_a    = bypass_in_hi[s];
      wire asy     = cfg.sr_mode[2];
      wire set_en  = (cfg.sr_mode == LSL_SR_SYNC_SET)
                  || (cfg.sr_mode == LSL_SR_SYNC_BOTH)
                  || (cfg.sr_mode == LSL_SR_ASYNC_PRE)
                  || (cfg.sr_mode == LSL_SR_ASYNC_BOTH);
      wire rst_en  = (cfg.sr_mode == LSL_SR_SYNC_RST)
                  || (cfg.sr_mode == LSL_SR_SYNC_BOTH)
                  || (cfg.sr_mode == LSL_SR_ASYNC_CLR)
                  || (cfg.sr_mode == LSL_SR_ASYNC_BOTH);
      // Combiners: five-input, then wide by slice position
      wire lo = gen_comb[2*s];
      wire hi = gen_comb[2*s+1];
      assign f5_comb[s] = bypass_in_lo[s] ? hi : lo;
      if (s == 0)
      begin : g_f6a
         assign fx_comb[s] = bypass_in_hi[s] ? f5_comb[1] : f5_comb[0];
      end
      else if (s == 1)
      begin : g_f7
         assign fx_comb[s] = bypass_in_hi[s] ? fx_comb[2] : fx_comb[0];
      end
      else if (s == 2)
      begin : g_f6b
         assign fx_comb[s] = bypass_in_hi[s] ? f5_comb[3] : f5_comb[2];
      end
      else
      begin : g_f8
         assign fx_comb[s] = bypass_in_hi[s] ? ext_f7_in : fx_comb[1];
      end
      // Storage elements
      for (genvar e = 0; e < 2; e++)
      begin : g_st
         wire byp   = e ? bypass_in_hi[s] : bypass_in_lo[s];
         wire d     = cfg.bypass_sel[e] ? byp : gen_comb[2*s+e];
         wire fone  = cfg.force_one_attr[e];
         wire set_c = set_en && (fone ? sr_a : by_a);
         wire rst_c = rst_en && (fone ? by_a : sr_a);
         wire upd   = (cfg.latch_mode[e] ? clk_eff : st_edge) && ce_ok;
         wire cur   = store_reg[2*s+e];
         // Async terms act without a storage clock edge
         assign store_next[2*s+e] =
            init_req_reg         ? cfg.init_one_attr[e] :
            (asy && rst_c)       ? 1'b0 :
            (asy && set_c)       ? 1'b1 :
            !upd                 ? cur :
            (!asy && rst_c)      ? 1'b0 :
            (!asy && set_c)      ? 1'b1 :
            d;
      end
   end

   // Generator tables
   lsl_gen_mem
   #(
      .NGEN  (NGEN),
      .DEPTH (LW)
   )
   u_tables
   (
      .clk     (hclk),
      .rst_n   (hresetn),
      .en      (clk_en),
      .bit_we  (bit_we),
      .bit_wd  (bit_wd),
      .table_q (table_q)
   );

   // Bus slave
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         req_reg       <= '0;
         wr_pend_reg   <= 1'b0;
         bus_state_reg <= LSL_BUS_IDLE;
         hreadyout_reg <= 1'b1;
         hrdata_reg    <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         wr_pend_reg <= 1'b0;
         case (bus_state_reg)
            LSL_BUS_IDLE:
            begin
               if (ahb_go)
               begin
                  req_reg       <= '{addr: haddr[7:0], write: hwrite};
                  wr_pend_reg   <= hwrite;
                  hreadyout_reg <= hwrite;
                  bus_state_reg <= hwrite ? LSL_BUS_IDLE : LSL_BUS_RD;
               end
            end
            LSL_BUS_RD:
            begin
               hrdata_reg    <= rd_val;
               hreadyout_reg <= 1'b1;
               bus_state_reg <= LSL_BUS_IDLE;
            end
            default:
               bus_state_reg <= LSL_BUS_IDLE;
         endcase
      end
   end

   // Configuration registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mem_mode_reg <= LSL_MEM_LUT;
         init_req_reg <= 1'b1;
         for (int i = 0; i < NSLICE; i++)
            slice_cfg_reg[i] <= `LSL_SLICE_CFG_RST;
      end
      else if (clk_en)
      begin
         init_req_reg <= ctrl_init;
         if (wr_mode)
            mem_mode_reg <= lsl_mem_mode_t'(hwdata[`LSL_MODE_W-1:0]);
         for (int i = 0; i < NSLICE; i++)
            if (wr_fire && wr_idx == 6'(`LSL_IDX_SLICE_0 + i))
               slice_cfg_reg[i] <= lsl_slice_cfg_t'(hwdata[`LSL_SLICE_CFG_W-1:0]);
      end
   end

   // Fabric-side state and registered outputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clk_prev_reg <= '0;
         store_reg    <= '0;
         gen_out_reg  <= '0;
         f5_reg       <= '0;
         fx_reg       <= '0;
         rd_a_reg     <= 8'h00;
         rd_b_reg     <= 4'h0;
      end
      else if (clk_en)
      begin
         // Raw pin levels for edge detection
         clk_prev_reg <= storage_clk;
         store_reg   <= store_next;
         gen_out_reg <= gen_comb;
         f5_reg      <= f5_comb;
         fx_reg      <= fx_comb;
         rd_a_reg    <= rd_a_comb;
         rd_b_reg    <= rd_b_comb;
      end
   end

   assign hreadyout   = hreadyout_reg;
   assign hresp       = 1'b0;
   assign hrdata      = hrdata_reg;
   assign gen_out     = gen_out_reg;
   assign store_out   = store_reg;
   assign f5_out      = f5_reg;
   assign fx_out      = fx_reg;
   assign mem_rdata_a = rd_a_reg;
   assign mem_rdata_b = rd_b_reg;

endmodule : lsl_cell

// ===== include/lsl_params.svh
`ifndef LSL_PARAMS_SVH
`define LSL_PARAMS_SVH

// Register byte offsets
`define LSL_OFS_LUT_INIT   8'h00
`define LSL_OFS_CELL_CFG   8'h20
`define LSL_OFS_SLICE_CFG  8'h24
`define LSL_OFS_STATUS     8'h34
`define LSL_OFS_CTRL       8'h38

// Register word indices
`define LSL_IDX_LUT_LAST   6'h07
`define LSL_IDX_CELL_CFG   6'h08
`define LSL_IDX_SLICE_0    6'h09
`define LSL_IDX_SLICE_3    6'h0C
`define LSL_IDX_STATUS     6'h0D
`define LSL_IDX_CTRL       6'h0E

// Field positions and widths
`define LSL_LUT_W          16
`define LSL_MODE_W         3
`define LSL_SLICE_CFG_W    15
`define LSL_CTRL_INIT_BIT  0
`define LSL_STATUS_STORE   8

// Reset values
`define LSL_LUT_RST        16'h0000
`define LSL_MODE_RST       3'h0
`define LSL_SLICE_CFG_RST  15'h0000

// Cell geometry
`define LSL_SLICES         4
`define LSL_GENS           8
`define LSL_ADDR_W         7

`endif

// ===== include/lsl_pkg.sv
package lsl_pkg;

   typedef enum logic [2:0] {
      LSL_SR_NONE       = 3'h0,
      LSL_SR_SYNC_SET   = 3'h1,
      LSL_SR_SYNC_RST   = 3'h2,
      LSL_SR_SYNC_BOTH  = 3'h3,
      LSL_SR_ASYNC_PRE  = 3'h4,
      LSL_SR_ASYNC_CLR  = 3'h5,
      LSL_SR_ASYNC_BOTH = 3'h6
   } lsl_sr_mode_t;

   typedef enum logic [2:0] {
      LSL_MEM_LUT     = 3'h0,
      LSL_MEM_SP16X8  = 3'h1,
      LSL_MEM_SP32X4  = 3'h2,
      LSL_MEM_SP64X2  = 3'h3,
      LSL_MEM_SP128X1 = 3'h4,
      LSL_MEM_DP16X4  = 3'h5,
      LSL_MEM_DP32X2  = 3'h6,
      LSL_MEM_DP64X1  = 3'h7
   } lsl_mem_mode_t;

   typedef enum logic {
      LSL_BUS_IDLE = 1'b0,
      LSL_BUS_RD   = 1'b1
   } lsl_bus_state_t;

   // Per-slice configuration, top bit (14) downward
   typedef struct packed {
      logic         ce_used;
      logic         sr_inv;
      logic         ce_inv;
      logic         clk_inv;
      lsl_sr_mode_t sr_mode;
      logic [1:0]   init_one_attr;
      logic [1:0]   force_one_attr;
      logic [1:0]   bypass_sel;
      logic [1:0]   latch_mode;
   } lsl_slice_cfg_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       write;
   } lsl_ahb_req_t;

endpackage : lsl_pkg

// ===== rtl/lsl_gen_mem.sv
`timescale 1ns/1ps
module lsl_gen_mem
#(
   parameter int NGEN  = 8,
   parameter int DEPTH = 16
)
(
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    en,
   input  wire logic [NGEN*DEPTH-1:0]   bit_we,
   input  wire logic [NGEN*DEPTH-1:0]   bit_wd,
   output logic      [NGEN*DEPTH-1:0]   table_q
);
   if (NGEN < 1 || DEPTH != 16)
   begin : g_bad
      $error("lsl_gen_mem: unsupported geometry");
   end

   // One storage bit per table entry
   for (genvar i = 0; i < NGEN*DEPTH; i++)
   begin : g_bit
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
            table_q[i] <= 1'b0;
         else if (en && bit_we[i])
            table_q[i] <= bit_wd[i];
      end
   end
endmodule : lsl_gen_mem

// ===== tb/lsl_cell_assertions.sv
`timescale 1ns/1ps
module lsl_cell_assertions
   import lsl_pkg::*;
#(
   parameter int NSLICE = 4
)
(
   input wire logic                  hclk,
   input wire logic                  hresetn,
   input wire logic                  clk_en,
   input wire logic                  hsel,
   input wire logic [1:0]            htrans,
   input wire logic                  hwrite,
   input wire logic                  hready,
   input wire logic                  hreadyout,
   input wire logic                  hresp,
   input wire logic [31:0]           hrdata,
   input wire logic [NSLICE-1:0]     bypass_in_lo,
   input wire logic [NSLICE*2-1:0]   gen_out,
   input wire logic [NSLICE-1:0]     f5_out,
   input wire logic [7:0]            mem_rdata_a
);
   wire logic take;
   assign take = hsel && htrans[1] && hready && clk_en;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_okay;
      hresp == 1'h0;
   endproperty
   a_okay: assert property (p_okay) else $error("hresp not OKAY");
   property p_wr_zero_wait;
      take && hwrite |=> hreadyout;
   endproperty
   a_wr_zero_wait: assert property (p_wr_zero_wait) else $error("write stalled");
   property p_rd_wait;
      take && !hwrite ##1 clk_en |-> !hreadyout ##1 hreadyout;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_one_wait;
      !hreadyout && clk_en |=> hreadyout;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait state too long");
   property p_rd_hold;
      hreadyout && $past(hreadyout) |-> $stable(hrdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("hrdata changed outside read");
   property p_f5;
      $past(clk_en) |-> f5_out[0] == ($past(bypass_in_lo[0]) ? gen_out[1] : gen_out[0]);
   endproperty
   a_f5: assert property (p_f5) else $error("combiner output wrong");
   property p_rst_out;
      $rose(hresetn) |-> gen_out == 8'h00 && mem_rdata_a == 8'h00 && hreadyout;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
   property p_freeze;
      !clk_en |=> $stable(gen_out) && $stable(hreadyout);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with clk_en low");
endmodule : lsl_cell_assertions

bind lsl_cell lsl_cell_assertions #(.NSLICE(NSLICE)) lsl_cell_assertions_i (.hclk, .hresetn,
   .clk_en, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .bypass_in_lo,
   .gen_out, .f5_out, .mem_rdata_a);

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import lsl_pkg::*;
   typedef struct packed {logic [7:0] a; logic [31:0] wd; logic [31:0] ex;} lsl_row_t;
   logic        hclk = 1'h0;
   logic        hresetn = 1'h0;
   logic        clk_en = 1'h1;
   logic        hsel = 1'h0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] gen_in = 32'h0000_0000;
   logic [3:0]  bypass_in_lo = 4'h0;
   logic [3:0]  bypass_in_hi = 4'h0;
   logic [3:0]  storage_clk = 4'h0;
   logic [3:0]  storage_ce = 4'h0;
   logic [3:0]  set_reset_in = 4'h0;
   logic        ext_f7_in = 1'h0;
   logic [6:0]  mem_addr = 7'h00;
   logic [6:0]  mem_addr_b = 7'h00;
   logic [7:0]  mem_wdata = 8'h00;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [7:0]  gen_out;
   logic [7:0]  store_out;
   logic [7:0]  mem_rdata_a;
   logic [3:0]  f5_out;
   logic [3:0]  fx_out;
   logic [3:0]  mem_rdata_b;
   logic [31:0] rd;
   int          bad_count = 0;
   int          checks_done = 0;
   lsl_row_t    rows [6] = '{
      '{8'h00, 32'h0000_6996, 32'h0000_6996},
      '{8'h04, 32'hFFFF_8001, 32'h0000_8001},
      '{8'h20, 32'h0000_000F, 32'h0000_0007},
      '{8'h24, 32'hFFFF_FFFF, 32'h0000_7FFF},
      '{8'h38, 32'h0000_0000, 32'h0000_0000},
      '{8'h3C, 32'h1234_5678, 32'h0000_0000}};

   always #5 hclk = ~hclk;

   lsl_cell #(.NSLICE(4)) lsl_cell_i (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .gen_in,
      .bypass_in_lo, .bypass_in_hi, .storage_clk, .storage_ce, .set_reset_in, .ext_f7_in,
      .mem_addr, .mem_addr_b, .mem_wdata, .gen_out, .store_out, .f5_out, .fx_out,
      .mem_rdata_a, .mem_rdata_b);

   task automatic wrap_up;
      $display("Checks %0d, errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   task automatic chk_bus(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checks_done++;
      if (got !== ex)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk_bus

   task automatic chk_pin(input string nm, input logic [7:0] ex, input logic [7:0] got);
      checks_done++;
      if (got !== ex)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk_pin

   task automatic step(input int n);
      repeat (n) @(posedge hclk);
   endtask : step

   task automatic wait_rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'h1 && n < 40);
      if (hreadyout !== 1'h1)
      begin
         bad_count++;
         wrap_up();
      end
   endtask : wait_rdy

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'h1;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : bus

   task automatic pulse;
      storage_clk[0] <= 1'h1;
      step(3);
      storage_clk[0] <= 1'h0;
      step(3);
   endtask : pulse

   initial
   begin
      step(2);
      hresetn <= 1'h1;
      step(1);
      foreach (rows[i])
      begin
         bus(1'h1, rows[i].a, rows[i].wd);
         bus(1'h0, rows[i].a, 32'h0000_0000);
         chk_bus("reg", rows[i].ex, rd);
      end
      hresetn <= 1'h0;
      step(2);
      hresetn <= 1'h1;
      step(1);
      foreach (rows[i])
      begin
         bus(1'h0, rows[i].a, 32'h0000_0000);
         chk_bus("rst", 32'h0000_0000, rd);
      end
      bus(1'h1, 8'h00, 32'h0000_6996);
      bus(1'h1, 8'h04, 32'h0000_8001);
      for (int i = 0; i < 16; i++)
      begin
         logic e;
         gen_in[7:0] <= {i[3:0], i[3:0]};
         bypass_in_lo[0] <= i[0];
         bypass_in_hi <= {i[2], 2'h0, i[1]};
         ext_f7_in <= i[3];
         step(2);
         e = i[1] ? 1'h0 : (i[0] ? (i == 15) : ^i[3:0]);
         chk_pin("gen", {6'h00, (i == 0 || i == 15), ^i[3:0]}, gen_out);
         chk_pin("f5", {7'h00, i[0] ? (i == 15) : ^i[3:0]}, {4'h0, f5_out});
         chk_pin("fx", {4'h0, i[2] ? i[3] : e, 1'h0, e, e}, {4'h0, fx_out});
      end
      bypass_in_hi <= 4'h0;
      clk_en <= 1'h0;
      gen_in[3:0] <= 4'h1;
      step(3);
      chk_pin("frz", 8'h02, gen_out);
      clk_en <= 1'h1;
      gen_in[7:0] <= 8'h01;
      step(1);
      pulse();
      chk_pin("ff", 8'h03, store_out);
      gen_in[7:0] <= 8'h33;
      bus(1'h1, 8'h24, 32'h0000_4000);
      pulse();
      chk_pin("ce", 8'h03, store_out);
      bus(1'h1, 8'h24, 32'h0000_5000);
      pulse();
      chk_pin("cei", 8'h00, store_out);
      bus(1'h1, 8'h24, 32'h0000_0004);
      bypass_in_lo[0] <= 1'h1;
      pulse();
      chk_pin("byp", 8'h01, store_out);
      bus(1'h1, 8'h24, 32'h0000_0800);
      storage_clk[0] <= 1'h1;
      step(3);
      chk_pin("inv", 8'h01, store_out);
      storage_clk[0] <= 1'h0;
      step(3);
      chk_pin("inv", 8'h00, store_out);
      bus(1'h1, 8'h24, 32'h0000_0001);
      gen_in[7:0] <= 8'h01;
      storage_clk[0] <= 1'h1;
      step(3);
      chk_pin("lat", 8'h03, store_out);
      gen_in[7:0] <= 8'h03;
      step(3);
      chk_pin("lat", 8'h02, store_out);
      storage_clk[0] <= 1'h0;
      gen_in[7:0] <= 8'h33;
      bus(1'h1, 8'h24, 32'h0000_0130);
      set_reset_in[0] <= 1'h1;
      pulse();
      chk_pin("sset", 8'h03, store_out);
      bypass_in_hi[0] <= 1'h1;
      bus(1'h1, 8'h24, 32'h0000_0330);
      pulse();
      chk_pin("sboth", 8'h00, store_out);
      bypass_in_hi[0] <= 1'h0;
      bus(1'h1, 8'h24, 32'h0000_0430);
      step(3);
      chk_pin("apre", 8'h03, store_out);
      bypass_in_hi[0] <= 1'h1;
      bus(1'h1, 8'h24, 32'h0000_0630);
      step(3);
      chk_pin("aboth", 8'h00, store_out);
      set_reset_in[0] <= 1'h0;
      bypass_in_hi[0] <= 1'h0;
      bus(1'h1, 8'h24, 32'h0000_00C0);
      bus(1'h1, 8'h38, 32'h0000_0001);
      step(2);
      chk_pin("init", 8'h03, store_out);
      bus(1'h0, 8'h34, 32'h0000_0000);
      chk_bus("stat", 32'h0000_0300, rd);
      bus(1'h1, 8'h20, 32'h0000_0001);
      mem_addr <= 7'h05;
      mem_wdata <= 8'hA5;
      set_reset_in[0] <= 1'h1;
      pulse();
      chk_pin("mem", 8'hA5, mem_rdata_a);
      set_reset_in[0] <= 1'h0;
      mem_addr <= 7'h06;
      mem_wdata <= 8'hFF;
      pulse();
      chk_pin("we", 8'h00, mem_rdata_a);
      bus(1'h1, 8'h20, 32'h0000_0005);
      mem_addr <= 7'h03;
      mem_addr_b <= 7'h03;
      mem_wdata <= 8'h0C;
      set_reset_in[0] <= 1'h1;
      pulse();
      chk_pin("dpa", 8'h0C, mem_rdata_a);
      chk_pin("dpb", 8'h0C, {4'h0, mem_rdata_b});
      set_reset_in[0] <= 1'h0;
      mem_addr_b <= 7'h05;
      step(2);
      chk_pin("dpb", 8'h0A, {4'h0, mem_rdata_b});
      chk_pin("dpa", 8'h0C, mem_rdata_a);
      wrap_up();
   end
endmodule : tb_top
